// File: spwm_chan.v
// Purpose: Counter and compare stage of one channel
// Assumes: tick comes from the channel prescaler
// Notes: Output lags the counter by one cycle
`timescale 1ns/1ps
`default_nettype none
`include "spwm_defs.vh"
module spwm_chan
(
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	input wire ce,
	// Active settings
	input wire tick,
	input wire run,
	input wire updown,
	input wire pol,
	input wire [15:0] top,
	input wire [15:0] thr,
	// Modulated output
	output reg pwm_out
);
	reg [15:0] cnt;
	reg down;
	wire below;

	assign below = (cnt < thr);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt <= `SPWM_CNT_RST;
			down <= 1'b0;
			pwm_out <= 1'b0;
		end
		else if (ce)
		begin
			if (!run)
			begin
				cnt <= `SPWM_CNT_RST; // RQ13
				down <= 1'b0;
				pwm_out <= ~pol;
			end
			else
			begin
				// Toggle at the threshold; polarity picks the level below it
				pwm_out <= pol ? below : ~below; // RQ5 RQ6 RQ13
				if (tick)
				begin
					if (!updown)
					begin
						down <= 1'b0;
						if (cnt >= top)
							cnt <= `SPWM_CNT_RST; // RQ4
						else
							cnt <= cnt + 16'h0001;
					end
					else if (down)
					begin
						if (cnt <= 16'h0001)
						begin
							cnt <= `SPWM_CNT_RST;
							down <= 1'b0;
						end
						else
							cnt <= cnt - 16'h0001; // RQ7
					end
					else if (cnt >= top)
					begin
						// Top of zero or one has nothing to descend, so no down phase
						down <= (top > 16'h0001); // RQ7
						cnt <= (top != 16'h0000) ? cnt - 16'h0001 : `SPWM_CNT_RST;
					end
					else
						cnt <= cnt + 16'h0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: spwm_defs.vh
// Purpose: Constants for the six channel pulse width modulator
// Assumes: Byte offsets are relative to the block base address
// Notes: Definitions only
`ifndef SPWM_DEFS_VH
`define SPWM_DEFS_VH

// Register byte offsets
`define SPWM_GCTL_OFS 8'h00
`define SPWM_CH_BASE 8'h04
`define SPWM_CH_LAST 8'h33
`define SPWM_STAT_OFS 8'h44

// Global control fields, both must be set
`define SPWM_GCTL_EN_A 0
`define SPWM_GCTL_EN_B 4
`define SPWM_GCTL_RST 8'h00

// Channel control word fields
`define SPWM_CTRL_EN 0
`define SPWM_CTRL_LOAD 1
`define SPWM_CTRL_POL 2
`define SPWM_CTRL_UPDN 3
`define SPWM_CTRL_PSC_LO 4
`define SPWM_CTRL_PSC_HI 6
`define SPWM_CTRL_RST 7'h00
`define SPWM_CTRL_W 7
`define SPWM_PSC_MAX 3'h6

// Channel counts word: top count high half, threshold low half
`define SPWM_TOP_LO 16
`define SPWM_THR_LO 0
`define SPWM_CNT_RST 16'h0000

// Register kinds returned by the decoder
`define SPWM_K_GCTL 3'h0
`define SPWM_K_CTRL 3'h1
`define SPWM_K_CNTS 3'h2
`define SPWM_K_STAT 3'h3
`define SPWM_K_NONE 3'h4

// Bus responses
`define SPWM_RESP_OK 2'h0
`define SPWM_RESP_ERR 2'h2

// Master clock derived from aclk by a fractional accumulator
`define SPWM_ACLK_KHZ 250000
`define SPWM_MCLK_KHZ 16000
`define SPWM_ACC_STEP 9'h010
`define SPWM_ACC_MOD 9'h0FA

`endif

// File: spwm_end_marker_unused.v
// Purpose: Reserved file, holds no logic
// Assumes: Nothing
// Notes: The block is spwm_top with its prescaler and channel modules

// File: spwm_load.sv
// Purpose: Load on the output pins, times each waveform
// Assumes: One sample per aclk
// Notes: Times are in aclk cycles, counted from rising output edges
`timescale 1ns/1ps
`default_nettype none
module spwm_load #(parameter NCH = 6)
(
	// Pins
	input wire logic aclk,
	input wire logic [NCH-1:0] pwm_out,
	// Measurements
	output int hi_t [NCH],
	output int per_t [NCH],
	output int rises [NCH]
);
	int age [NCH];
	logic [NCH-1:0] last = '0;
	always @(posedge aclk)
	begin
		for (int i = 0; i < NCH; i++)
		begin
			age[i] <= age[i] + 1;
			if (pwm_out[i] && !last[i])
			begin
				per_t[i] <= age[i];
				age[i] <= 1;
				rises[i] <= rises[i] + 1;
			end
			if (!pwm_out[i] && last[i])
				hi_t[i] <= age[i];
		end
		last <= pwm_out;
	end
endmodule
`default_nettype wire

// File: spwm_prescale.v
// Purpose: Power of two prescaler for one channel
// Assumes: mtick is a one cycle 16 MHz master tick
// Notes: Codes above six behave as six
`timescale 1ns/1ps
`default_nettype none
`include "spwm_defs.vh"
module spwm_prescale
(
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	input wire ce,
	// Control
	input wire mtick,
	input wire run,
	input wire [2:0] code,
	// Divided tick
	output reg tick
);
	wire [2:0] k;
	wire [6:0] last;
	reg [6:0] cnt;

	assign k = (code > `SPWM_PSC_MAX) ? `SPWM_PSC_MAX : code;
	// Ratio two to the k plus one; 128 wraps to zero so last is 127
	assign last = (7'h02 << k) - 7'h01; // RQ12

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt <= 7'h00;
			tick <= 1'b0;
		end
		else if (ce)
		begin
			tick <= 1'b0;
			if (!run)
				cnt <= 7'h00;
			else if (mtick)
			begin
				if (cnt == last)
				begin
					cnt <= 7'h00;
					tick <= 1'b1; // RQ3
				end
				else
					cnt <= cnt + 7'h01;
			end
		end
	end
endmodule
`default_nettype wire

// File: spwm_top.v
// Purpose: Six channel pulse width modulator with AXI4-Lite registers
// Assumes: aclk at 250 MHz; master tick of 16 MHz made from it
// Notes: ce low freezes every flip-flop, the bus included
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "spwm_defs.vh"

// Operation
// (RQ1) Six outputs, each with its own counter and settings, set independently.
// (RQ2) All counting comes from one 16 MHz master tick into each prescaler.
// (RQ3) Each channel divides the master tick by a power of two, 2 to 128.
// (RQ4) Up mode counts zero to top count, then returns to zero.
// (RQ5) Output toggles where the counter meets the threshold.
// (RQ6) Polarity picks the output level below the threshold, opposite above it.
// (RQ7) Up/down mode counts up to top count, then back down.
// (RQ8) Settings: top, threshold, prescaler code, polarity, mode, enable, load enable.
// (RQ9) Written settings become active only while load enable is set.
// (RQ10) Channel registers sit from offset 0x04 through 0x44; the code decodes them only through 0x33 and puts status at 0x44.
// (RQ11) Software sets global bits 0 and 4 before programming channels.
// (RQ12) Prescaler code k selects ratio two to the power k plus one.
// (RQ13) Positive polarity drives high below threshold; disabled channel holds zero. The code holds a disabled channel at the inverse of its polarity bit.
module spwm_top #
(
	parameter NCH = 6,
	parameter AW = 8
)
(
	// Clock, reset, enable
	input wire aclk,
	input wire aresetn,
	input wire ce,
	// Write address channel
	input wire [AW-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// Write data channel
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// Write response channel
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// Read address channel
	input wire [AW-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// Read data channel
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Modulated outputs
	output wire [NCH-1:0] pwm_out
);
	// Register kind of a byte address
	function [2:0] reg_kind;
		input [AW-1:0] a;
		begin
			if (a[1:0] != 2'h0)
				reg_kind = `SPWM_K_NONE;
			else if (a == `SPWM_GCTL_OFS)
				reg_kind = `SPWM_K_GCTL;
			else if (a == `SPWM_STAT_OFS)
				reg_kind = `SPWM_K_STAT;
			else if (a >= `SPWM_CH_BASE && a <= `SPWM_CH_LAST)
				reg_kind = a[2] ? `SPWM_K_CTRL : `SPWM_K_CNTS;
			else
				reg_kind = `SPWM_K_NONE;
		end
	endfunction

	// Channel index: control at 04+8n, counts at 08+8n
	function [2:0] reg_ch;
		input [AW-1:0] a;
		reg [AW-1:0] rel;
		begin
			rel = a - `SPWM_CH_BASE;
			reg_ch = rel[5:3];
		end
	endfunction

	// Byte lane merge under write strobes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (strb[b])
					merge[b*8 +: 8] = nw[b*8 +: 8];
		end
	endfunction

	// Write holding state
	reg [AW-1:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	// Registers as software sees them
	reg [7:0] gctl;
	reg [NCH*`SPWM_CTRL_W-1:0] pend_ctrl;
	reg [NCH*32-1:0] pend_cnts;
	// Master tick accumulator
	reg [8:0] acc;
	reg mtick;

	wire g_ok;
	wire do_wr;
	wire [2:0] wr_kind;
	wire [2:0] wr_ch;
	wire [2:0] rd_kind;
	wire [2:0] rd_ch;
	wire [NCH-1:0] act_en;
	wire [8:0] acc_sum;
	wire [31:0] gctl_m;
	wire [31:0] ctrl_m;
	reg [31:0] rd_word;
	integer i;

	assign g_ok = gctl[`SPWM_GCTL_EN_A] & gctl[`SPWM_GCTL_EN_B];
	// Address and data are both held and no response is outstanding
	assign do_wr = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	assign wr_kind = reg_kind(aw_addr);
	assign wr_ch = reg_ch(aw_addr);
	assign rd_kind = reg_kind(s_axi_araddr);
	assign rd_ch = reg_ch(s_axi_araddr);
	assign acc_sum = acc + `SPWM_ACC_STEP;
	// Only the addressed channel is written, so one merged word serves all six
	assign gctl_m = merge({24'h000000, gctl}, w_data, w_strb);
	assign ctrl_m = merge({25'h0000000, pend_ctrl[wr_ch*`SPWM_CTRL_W +: `SPWM_CTRL_W]},
		w_data, w_strb);

	// 16 ticks every 250 cycles: 16 MHz on average with bounded jitter
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			acc <= 9'h000;
			mtick <= 1'b0;
		end
		else if (ce)
		begin
			if (acc_sum >= `SPWM_ACC_MOD)
			begin
				acc <= acc_sum - `SPWM_ACC_MOD; // RQ2
				mtick <= 1'b1;
			end
			else
			begin
				acc <= acc_sum;
				mtick <= 1'b0;
			end
		end
	end

	// Write side: address and data taken in either order
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SPWM_RESP_OK;
			aw_addr <= {AW{1'b0}};
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			gctl <= `SPWM_GCTL_RST;
			pend_ctrl <= {NCH{`SPWM_CTRL_RST}};
			pend_cnts <= {NCH{32'h00000000}};
		end
		else if (ce)
		begin
			if (s_axi_awready && s_axi_awvalid)
			begin
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wready && s_axi_wvalid)
			begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_wr)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_kind == `SPWM_K_NONE) ? `SPWM_RESP_ERR : `SPWM_RESP_OK;
				if (wr_kind == `SPWM_K_GCTL)
					gctl <= gctl_m[7:0];
				// Channel writes are dropped until the global enables are set
				for (i = 0; i < NCH; i = i + 1)
				begin
					if (g_ok && wr_ch == i && wr_kind == `SPWM_K_CTRL) // RQ11 RQ10
						pend_ctrl[i*`SPWM_CTRL_W +: `SPWM_CTRL_W] <= ctrl_m[`SPWM_CTRL_W-1:0];
					if (g_ok && wr_ch == i && wr_kind == `SPWM_K_CNTS) // RQ11 RQ10
						pend_cnts[i*32 +: 32] <= merge(pend_cnts[i*32 +: 32], w_data, w_strb);
				end
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Read word mux
	always @*
	begin
		rd_word = 32'h00000000;
		case (rd_kind)
			`SPWM_K_GCTL:
				rd_word = {24'h000000, gctl};
			`SPWM_K_CTRL:
				rd_word = {25'h0000000, pend_ctrl[rd_ch*`SPWM_CTRL_W +: `SPWM_CTRL_W]};
			`SPWM_K_CNTS:
				rd_word = pend_cnts[rd_ch*32 +: 32];
			`SPWM_K_STAT:
				rd_word = {15'h0000, g_ok, 2'h0, act_en, 2'h0, pwm_out};
			default:
				rd_word = 32'h00000000;
		endcase
	end

	// Read side: data registered at the address handshake
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SPWM_RESP_OK;
		end
		else if (ce)
		begin
			if (s_axi_arready && s_axi_arvalid)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (rd_kind == `SPWM_K_NONE) ? `SPWM_RESP_ERR : `SPWM_RESP_OK;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// One independent channel per index
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1)
		begin : ch
			reg [`SPWM_CTRL_W-1:0] act_ctrl;
			reg [15:0] act_top;
			reg [15:0] act_thr;
			wire [`SPWM_CTRL_W-1:0] pc;
			wire tick;
			wire run;

			assign pc = pend_ctrl[g*`SPWM_CTRL_W +: `SPWM_CTRL_W];
			assign run = g_ok & act_ctrl[`SPWM_CTRL_EN];
			assign act_en[g] = act_ctrl[`SPWM_CTRL_EN];

			// Shadow copy follows the written settings only while load is set
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					act_ctrl <= `SPWM_CTRL_RST;
					act_top <= `SPWM_CNT_RST;
					act_thr <= `SPWM_CNT_RST;
				end
				else if (ce && pc[`SPWM_CTRL_LOAD])
				begin
					act_ctrl <= pc; // RQ9 RQ8
					act_top <= pend_cnts[g*32+`SPWM_TOP_LO +: 16]; // RQ9 RQ8
					act_thr <= pend_cnts[g*32+`SPWM_THR_LO +: 16]; // RQ9 RQ8
				end
			end

			spwm_prescale u_psc
			(
				.aclk(aclk),
				.aresetn(aresetn),
				.ce(ce),
				.mtick(mtick),
				.run(run),
				.code(act_ctrl[`SPWM_CTRL_PSC_HI:`SPWM_CTRL_PSC_LO]),
				.tick(tick)
			);

			spwm_chan u_chan // RQ1
			(
				.aclk(aclk),
				.aresetn(aresetn),
				.ce(ce),
				.tick(tick),
				.run(run),
				.updown(act_ctrl[`SPWM_CTRL_UPDN]),
				.pol(act_ctrl[`SPWM_CTRL_POL]),
				.top(act_top),
				.thr(act_thr),
				.pwm_out(pwm_out[g])
			);
		end
	endgenerate
endmodule
`default_nettype wire

// File: spwm_top_properties.sv
// Purpose: Bus and output timing checks for spwm_top
// Assumes: Checks pause while ce is low
// Notes: Bound into every spwm_top
`timescale 1ns/1ps
`default_nettype none
module spwm_top_properties #(parameter NCH = 6, parameter AW = 8)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Outputs
	input wire logic [NCH-1:0] pwm_out
);
	logic [3:0] quiet;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);
	// Bus writes may legally move outputs, so only quiet stretches are judged
	always @(posedge aclk)
		if (!aresetn || s_axi_bvalid)
			quiet <= 4'h0;
		else if (quiet != 4'hF)
			quiet <= quiet + 4'h1;
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_wr_resp;
		s_wr |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("no write response");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_b_free;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
	endproperty
	a_b_free: assert property (p_b_free) else $error("write path not freed");
	property p_aw_busy;
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
	endproperty
	a_aw_busy: assert property (p_aw_busy) else $error("second address taken");
	property p_rd_resp;
		s_rd |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("no read data");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data changed");
	property p_gap;
		s_rd ##0 s_axi_araddr inside {[8'h34:8'h40]} |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	a_gap: assert property (p_gap) else $error("gap address answered");
	property p_slow;
		quiet == 4'hF && $changed(pwm_out) |=> $stable(pwm_out);
	endproperty
	a_slow: assert property (p_slow) else $error("output moved too fast");
endmodule
bind spwm_top spwm_top_properties #(.NCH(NCH), .AW(AW)) chk_u (.aclk, .aresetn, .ce,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_out);
`default_nettype wire

// File: test_six_channel_pwm.sv
// Purpose: Self-checking bench for spwm_top
// Assumes: 250 MHz aclk, fixed seed
// Notes: Tick jitter makes waveform times good to about 20 cycles
`timescale 1ns/1ps
`default_nettype none
module test_six_channel_pwm;
	logic aclk = 0, aresetn = 0, ce = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [2:0] awp = 0, arp = 0;
	logic [31:0] wd = 0, d, v [6];
	logic [3:0] ws = 4'hF;
	wire logic awr, wr_r, bv, arr, rv;
	wire logic [1:0] br, rr;
	wire logic [31:0] rdd;
	wire logic [5:0] pwm;
	int hi_t [6], per_t [6], rises [6], num_errors = 0, n_tests = 0, r0;
	always #2 aclk = ~aclk;
	spwm_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awa),
		.s_axi_awprot(awp), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(arp),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rry), .pwm_out(pwm));
	spwm_load load_u (.aclk(aclk), .pwm_out(pwm), .hi_t(hi_t), .per_t(per_t), .rises(rises));
	task automatic test_done;
		$display("num_errors=%0d n_tests=%0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic hang;
		num_errors++;
		test_done;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
		int i;
		awa <= a;
		wd <= x;
		awp <= 3'($urandom);
		awv <= 1;
		wv <= 1;
		bry <= 1;
		for (i = 0; i < 64 && !bv; i++)
		begin
			@(posedge aclk);
			if (awr)
				awv <= 0;
			if (wr_r)
				wv <= 0;
		end
		if (i == 64)
			hang;
		bry <= 0;
		chk(br, e);
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] e);
		int i;
		ara <= a;
		arp <= 3'($urandom);
		arv <= 1;
		rry <= 1;
		for (i = 0; i < 64 && !rv; i++)
		begin
			@(posedge aclk);
			if (arr)
				arv <= 0;
		end
		if (i == 64)
			hang;
		rry <= 0;
		d = rdd;
		chk(rr, e);
		@(posedge aclk);
	endtask
	function automatic int cyc(int steps, int k);
		return steps * (2 << k) * 250 / 16;
	endfunction
	function automatic logic [31:0] near(int m, int e);
		return {31'h0, m >= e - 20 && m <= e + 20};
	endfunction
	// Counts first, then the control word, since load copies both at once
	task automatic cfg(int ch, int top, int thr, int k, int ud, int pol, int ld);
		wr(8'(8 + 8 * ch), {top[15:0], thr[15:0]}, 2'h0);
		wr(8'(4 + 8 * ch), {25'h0, k[2:0], ud[0], pol[0], ld[0], 1'h1}, 2'h0);
	endtask
	task automatic meas(int ch, int eh, int ep);
		int i;
		r0 = rises[ch];
		for (i = 0; i < 20000 && rises[ch] < r0 + 3; i++)
			@(posedge aclk);
		if (i == 20000)
			hang;
		chk(near(per_t[ch], ep), 32'h1);
		chk(near(hi_t[ch], eh), 32'h1);
		$display("channel %0d measured", ch);
	endtask
	initial
	begin
		void'($urandom(32'h36A44C55));
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(8'h04, 2'h0);
		chk(d, 32'h0);
		rd(8'h34, 2'h2);
		chk(d, 32'h0);
		rd(8'h05, 2'h2);
		wr(8'h40, 32'h1, 2'h2);
		wr(8'h08, 32'h12345678, 2'h0);
		rd(8'h08, 2'h0);
		chk(d, 32'h0);
		wr(8'h00, 32'h11, 2'h0);
		for (int c = 0; c < 6; c++)
		begin
			v[c] = $urandom;
			wr(8'(8 + 8 * c), v[c], 2'h0);
		end
		for (int c = 0; c < 6; c++)
		begin
			rd(8'(8 + 8 * c), 2'h0);
			chk(d, v[c]);
		end
		$display("registers done");
		cfg(0, 7, 3, 0, 0, 1, 1);
		meas(0, cyc(3, 0), cyc(8, 0));
		cfg(1, 7, 3, 0, 0, 0, 1);
		meas(1, cyc(5, 0), cyc(8, 0));
		cfg(2, 6, 2, 1, 1, 1, 1);
		meas(2, cyc(3, 1), cyc(12, 1));
		for (int k = 0; k < 7; k++)
		begin
			cfg(3, 1, 1, k, 0, 1, 1);
			meas(3, cyc(1, k), cyc(2, k));
		end
		r0 = 4 + $urandom % 16;
		v[0] = 1 + $urandom % r0;
		v[1] = $urandom % 3;
		cfg(4, r0, v[0], v[1], 0, 1, 1);
		meas(4, cyc(v[0], v[1]), cyc(r0 + 1, v[1]));
		// Load is a level, so drop it before new counts are written
		wr(8'h04, 32'h5, 2'h0);
		cfg(0, 7, 6, 0, 0, 1, 0);
		meas(0, cyc(3, 0), cyc(8, 0));
		ce <= 0;
		repeat (2) @(posedge aclk);
		r0 = rises[0];
		repeat (600) @(posedge aclk);
		chk(rises[0], r0);
		ce <= 1;
		@(posedge aclk);
		$display("freeze done");
		// Fast counts left pending, so a wrong load would toggle at once
		wr(8'h30, 32'h00010001, 2'h0);
		wr(8'h2C, 32'h5, 2'h0);
		r0 = rises[5];
		repeat (300) @(posedge aclk);
		chk(rises[5], r0);
		chk(pwm[5], 1'h1);
		rd(8'h44, 2'h0);
		chk(d[16:8], 9'h11F);
		$display("waveforms done");
		test_done;
	end
endmodule
`default_nettype wire
